// File: mau_divider.sv
`timescale 1ns/100ps
// unsigned restoring divider, one quotient bit per cycle
module mau_divider (
    input  wire logic                       clk_i,
    input  wire logic                       reset_i,
    input  wire logic                       start_i,
    input  wire logic [mau_pkg::DATA_W-1:0] dividend_i,
    input  wire logic [mau_pkg::DATA_W-1:0] divisor_i,
    output logic                            done_o,
    output logic [mau_pkg::DATA_W-1:0]      quot_o,
    output logic [mau_pkg::DATA_W-1:0]      rem_o
);
    import mau_pkg::*;

    typedef struct packed {
        logic              busy;
        logic              done;
        logic [5:0]        cnt;
        logic [DATA_W-1:0] quo;
        logic [DATA_W-1:0] rem;
        logic [DATA_W-1:0] dvs;
    } mau_div_st_t;

    mau_div_st_t s_q, s_d;
    logic [DATA_W:0] trial;

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        trial = {s_q.rem, s_q.quo[DATA_W-1]} - {1'b0, s_q.dvs};
        if (start_i) begin
            s_d.busy = 1'b1;
            s_d.cnt  = CNT_ZERO;
            s_d.quo  = dividend_i;
            s_d.rem  = '0;
            s_d.dvs  = divisor_i;
        end else if (s_q.busy) begin
            // divide by zero simply yields all-ones quotient, no trap
            if (!trial[DATA_W]) begin
                s_d.rem = trial[DATA_W-1:0];
                s_d.quo = {s_q.quo[DATA_W-2:0], 1'b1};
            end else begin
                s_d.rem = {s_q.rem[DATA_W-2:0], s_q.quo[DATA_W-1]};
                s_d.quo = {s_q.quo[DATA_W-2:0], 1'b0};
            end
            s_d.cnt = s_q.cnt + 6'h01;
            if (s_q.cnt == DIV_LAST) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) s_q <= '0;
        else s_q <= s_d;
    end

    assign done_o = s_q.done;
    assign quot_o = s_q.quo;
    assign rem_o  = s_q.rem;
endmodule

// File: mau_pkg.sv
// Behaviour
// - every multiply or divide except product-to-register writes the result pair
// - copy instructions move chosen half to register
// - product-to-register writes low product to register
// - product-to-register destination selectable among registers
// - multiply-add adds product into result pair
// - multiply-subtract subtracts product from result pair
package mau_pkg;
    localparam int unsigned DATA_W    = 32;
    localparam int unsigned ACC_W     = 64;
    localparam int unsigned REG_ADDR_W = 5;
    localparam int unsigned DIV_STEPS = 32;
    localparam logic [5:0]  DIV_LAST  = 6'h1f;
    localparam logic [5:0]  CNT_ZERO  = 6'h00;

    typedef enum logic [3:0] {
        MAU_OP_NONE   = 4'h0,
        MAU_OP_MULT   = 4'h1,
        MAU_OP_MULTU  = 4'h2,
        MAU_OP_DIV    = 4'h3,
        MAU_OP_DIVU   = 4'h4,
        MAU_OP_ACC_ADD = 4'h5,
        MAU_OP_ACC_SUB = 4'h6,
        MAU_OP_PROD   = 4'h7,
        MAU_OP_CPTOP  = 4'h8,
        MAU_OP_CPBOT  = 4'h9
    } mau_op_t;

    typedef enum logic [1:0] {
        MAU_IDLE = 2'b00,
        MAU_DIV  = 2'b01,
        MAU_FIX  = 2'b10
    } mau_state_t;
endpackage

// File: mau_regfile_model.sv
`timescale 1ns/100ps
// stands in for the core register file; keeps every write back it sees
module mau_regfile_model (
    input  wire logic                           clk_i,
    input  wire logic                           reset_i,
    input  wire logic                           wb_valid_i,
    input  wire logic [mau_pkg::REG_ADDR_W-1:0] wb_dest_i,
    input  wire logic [mau_pkg::DATA_W-1:0]     wb_data_i
);
    import mau_pkg::*;
    logic [DATA_W-1:0] regs_q [2**REG_ADDR_W];
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            for (int i = 0; i < 2**REG_ADDR_W; i++) begin
                regs_q[i] <= '0;
            end
        end else if (wb_valid_i) begin
            regs_q[wb_dest_i] <= wb_data_i;
        end
    end
endmodule

// File: mau_top.sv
`timescale 1ns/100ps
module mau_top (
    input  wire logic                           clk_i,
    input  wire logic                           reset_i,
    input  wire logic                           op_valid_i,
    input  wire mau_pkg::mau_op_t               op_i,
    input  wire logic [mau_pkg::DATA_W-1:0]     src_a_i,
    input  wire logic [mau_pkg::DATA_W-1:0]     src_b_i,
    input  wire logic [mau_pkg::REG_ADDR_W-1:0] dest_i,
    output logic                                busy_o,
    output logic                                wb_valid_o,
    output logic [mau_pkg::REG_ADDR_W-1:0]      wb_dest_o,
    output logic [mau_pkg::DATA_W-1:0]          wb_data_o,
    output logic [mau_pkg::DATA_W-1:0]          upper_result_half_o,
    output logic [mau_pkg::DATA_W-1:0]          bottom_result_half_o
);
    import mau_pkg::*;

    typedef struct packed {
        mau_state_t            st;
        logic                  neg_q;
        logic                  neg_r;
        logic [DATA_W-1:0]     upper;
        logic [DATA_W-1:0]     bottom;
        logic                  wb_v;
        logic [REG_ADDR_W-1:0] wb_a;
        logic [DATA_W-1:0]     wb_d;
    } mau_st_t;

    mau_st_t s_q, s_d;

    function automatic logic [DATA_W-1:0] mag(input logic [DATA_W-1:0] v, input logic sgn);
        mag = (sgn && v[DATA_W-1]) ? DATA_W'(-v) : v;
    endfunction

    logic              accept;
    logic              signed_op;
    logic [ACC_W-1:0]  prod;
    logic [ACC_W-1:0]  pair;
    logic              div_start;
    logic              div_done;
    logic [DATA_W-1:0] div_q;
    logic [DATA_W-1:0] div_r;

    assign accept    = op_valid_i && (s_q.st == MAU_IDLE);
    assign signed_op = (op_i != MAU_OP_MULTU) && (op_i != MAU_OP_DIVU);
    // 32x32 gives 64 bits: top word is the upper half
    assign prod = signed_op
        ? ACC_W'($signed({{DATA_W{src_a_i[DATA_W-1]}}, src_a_i})
                 * $signed({{DATA_W{src_b_i[DATA_W-1]}}, src_b_i}))
        : ACC_W'({{DATA_W{1'b0}}, src_a_i} * {{DATA_W{1'b0}}, src_b_i});
    assign pair = {s_q.upper, s_q.bottom};
    assign div_start = accept && ((op_i == MAU_OP_DIV) || (op_i == MAU_OP_DIVU));

    mau_divider u_div (
        .clk_i      (clk_i),
        .reset_i    (reset_i),
        .start_i    (div_start),
        .dividend_i (mag(src_a_i, op_i == MAU_OP_DIV)),
        .divisor_i  (mag(src_b_i, op_i == MAU_OP_DIV)),
        .done_o     (div_done),
        .quot_o     (div_q),
        .rem_o      (div_r)
    );

    always_comb begin
        s_d = s_q;
        s_d.wb_v = 1'b0;
        unique case (s_q.st)
            MAU_IDLE: begin
                if (accept) begin
                    unique case (op_i)
                        MAU_OP_MULT, MAU_OP_MULTU: begin
                            {s_d.upper, s_d.bottom} = prod;
                        end
                        MAU_OP_ACC_ADD: begin
                            {s_d.upper, s_d.bottom} = pair + prod;
                        end
                        MAU_OP_ACC_SUB: begin
                            {s_d.upper, s_d.bottom} = pair - prod;
                        end
                        MAU_OP_PROD: begin
                            // result pair left untouched here
                            s_d.wb_v = 1'b1;
                            s_d.wb_a = dest_i;
                            s_d.wb_d = prod[DATA_W-1:0];
                        end
                        MAU_OP_CPTOP: begin
                            s_d.wb_v = 1'b1;
                            s_d.wb_a = dest_i;
                            s_d.wb_d = s_q.upper;
                        end
                        MAU_OP_CPBOT: begin
                            s_d.wb_v = 1'b1;
                            s_d.wb_a = dest_i;
                            s_d.wb_d = s_q.bottom;
                        end
                        MAU_OP_DIV, MAU_OP_DIVU: begin
                            s_d.st    = MAU_DIV;
                            s_d.neg_q = (op_i == MAU_OP_DIV)
                                        && (src_a_i[DATA_W-1] ^ src_b_i[DATA_W-1]);
                            s_d.neg_r = (op_i == MAU_OP_DIV) && src_a_i[DATA_W-1];
                        end
                        default: begin
                        end
                    endcase
                end
            end
            MAU_DIV: begin
                if (div_done) s_d.st = MAU_FIX;
            end
            MAU_FIX: begin
                // remainder takes dividend sign, quotient truncates to zero
                s_d.bottom = s_q.neg_q ? DATA_W'(-div_q) : div_q;
                s_d.upper  = s_q.neg_r ? DATA_W'(-div_r) : div_r;
                s_d.st = MAU_IDLE;
            end
            default: s_d.st = MAU_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) s_q <= '0;
        else s_q <= s_d;
    end

    assign busy_o               = (s_q.st != MAU_IDLE);
    assign wb_valid_o           = s_q.wb_v;
    assign wb_dest_o            = s_q.wb_a;
    assign wb_data_o            = s_q.wb_d;
    assign upper_result_half_o  = s_q.upper;
    assign bottom_result_half_o = s_q.bottom;

    property p_mult_pair;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_MULTU)
            |=> {upper_result_half_o, bottom_result_half_o} == $past(prod);
    endproperty
    a_mult_pair: assert property (p_mult_pair) else $error("mult result not in pair");

    property p_copy_top;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_CPTOP)
            |=> wb_valid_o && wb_data_o == $past(upper_result_half_o);
    endproperty
    a_copy_top: assert property (p_copy_top) else $error("copy top wrong");

    property p_copy_bot;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_CPBOT)
            |=> wb_valid_o && wb_data_o == $past(bottom_result_half_o);
    endproperty
    a_copy_bot: assert property (p_copy_bot) else $error("copy bottom wrong");

    property p_prod_reg;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_PROD)
            |=> wb_valid_o && wb_data_o == $past(prod[DATA_W-1:0]) && $stable(upper_result_half_o)
                && $stable(bottom_result_half_o);
    endproperty
    a_prod_reg: assert property (p_prod_reg) else $error("product to register wrong");

    property p_prod_dest;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_PROD) |=> wb_dest_o == $past(dest_i);
    endproperty
    a_prod_dest: assert property (p_prod_dest) else $error("destination wrong");

    property p_acc_add;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_ACC_ADD)
            |=> {upper_result_half_o, bottom_result_half_o} == $past(pair) + $past(prod);
    endproperty
    a_acc_add: assert property (p_acc_add) else $error("multiply-add wrong");

    property p_acc_sub;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_ACC_SUB)
            |=> {upper_result_half_o, bottom_result_half_o} == $past(pair) - $past(prod);
    endproperty
    a_acc_sub: assert property (p_acc_sub) else $error("multiply-subtract wrong");

    // a request offered mid divide must leave the pair and write back alone
    property p_refuse;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == MAU_DIV) && op_valid_i
            |=> $stable(upper_result_half_o) && $stable(bottom_result_half_o) && !wb_valid_o;
    endproperty
    a_refuse: assert property (p_refuse) else $error("request taken while busy");

    property p_copy_dest;
        @(posedge clk_i) disable iff (reset_i)
        accept && ((op_i == MAU_OP_CPTOP) || (op_i == MAU_OP_CPBOT))
            |=> wb_dest_o == $past(dest_i);
    endproperty
    a_copy_dest: assert property (p_copy_dest) else $error("copy destination wrong");

    property p_wb_only;
        @(posedge clk_i) disable iff (reset_i)
        !(accept && ((op_i == MAU_OP_PROD) || (op_i == MAU_OP_CPTOP) || (op_i == MAU_OP_CPBOT)))
            |=> !wb_valid_o;
    endproperty
    a_wb_only: assert property (p_wb_only) else $error("stray register write");

    property p_div_pair;
        @(posedge clk_i) disable iff (reset_i)
        (s_q.st == MAU_FIX) && !s_q.neg_q && !s_q.neg_r
            |=> {upper_result_half_o, bottom_result_half_o} == $past({div_r, div_q});
    endproperty
    a_div_pair: assert property (p_div_pair) else $error("divide result not in pair");

    property p_divu;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_DIVU) && (src_b_i != '0)
            |=> busy_o [*8] ##[26:30] !busy_o;
    endproperty
    a_divu: assert property (p_divu) else $error("divide latency wrong");

    property p_signed_hi;
        @(posedge clk_i) disable iff (reset_i)
        accept && (op_i == MAU_OP_MULT) && (src_a_i == 32'hffffffff) && (src_b_i == 32'h00000002)
            |=> upper_result_half_o == 32'hffffffff && bottom_result_half_o == 32'hfffffffe;
    endproperty
    a_signed_hi: assert property (p_signed_hi) else $error("signed split wrong");

    c_acc_add: cover property (@(posedge clk_i) accept && op_i == MAU_OP_ACC_ADD);
    c_acc_sub: cover property (@(posedge clk_i) accept && op_i == MAU_OP_ACC_SUB);
    c_copy:    cover property (@(posedge clk_i) accept && op_i == MAU_OP_CPTOP);
    c_div:  cover property (@(posedge clk_i) s_q.st == MAU_FIX);
    c_prod: cover property (@(posedge clk_i) accept && op_i == MAU_OP_PROD);
endmodule

// File: mau_top_test.sv
`timescale 1ns/100ps
module mau_top_test;
    import mau_pkg::*;
    logic                  clk_i      = 1'b0;
    logic                  reset_i    = 1'b1;
    logic                  op_valid_i = 1'b0;
    mau_op_t               op_i       = MAU_OP_NONE;
    logic [DATA_W-1:0]     src_a_i    = '0;
    logic [DATA_W-1:0]     src_b_i    = '0;
    logic [REG_ADDR_W-1:0] dest_i     = '0;
    logic                  busy_o;
    logic                  wb_valid_o;
    logic [REG_ADDR_W-1:0] wb_dest_o;
    logic [DATA_W-1:0]     wb_data_o;
    logic [DATA_W-1:0]     upper_result_half_o;
    logic [DATA_W-1:0]     bottom_result_half_o;
    logic [ACC_W-1:0]      acc = '0;
    int                    n_fail = 0;
    int                    check_count = 0;
    int                    cycles = 0;

    always #50 clk_i = ~clk_i;

    mau_top mau_top_inst (.clk_i(clk_i), .reset_i(reset_i), .op_valid_i(op_valid_i),
        .op_i(op_i), .src_a_i(src_a_i), .src_b_i(src_b_i), .dest_i(dest_i),
        .busy_o(busy_o), .wb_valid_o(wb_valid_o), .wb_dest_o(wb_dest_o),
        .wb_data_o(wb_data_o), .upper_result_half_o(upper_result_half_o),
        .bottom_result_half_o(bottom_result_half_o));
    mau_regfile_model mau_regfile_model_inst (.clk_i(clk_i), .reset_i(reset_i),
        .wb_valid_i(wb_valid_o), .wb_dest_i(wb_dest_o), .wb_data_i(wb_data_o));

    task automatic report_and_stop();
        if (n_fail == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // fails and stops the run at 1000 cycles should anything hang
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            report_and_stop();
        end
    end

    function automatic logic [63:0] smul(input logic [31:0] a, input logic [31:0] b);
        return longint'(signed'(a)) * longint'(signed'(b));
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic check_pair(input string what);
        check({what, " upper"}, acc[63:32], upper_result_half_o);
        check({what, " bottom"}, acc[31:0], bottom_result_half_o);
    endtask

    task automatic issue(input mau_op_t op, input logic [31:0] a, input logic [31:0] b,
                         input logic [4:0] d);
        op_valid_i <= 1'b1;
        op_i <= op;
        src_a_i <= a;
        src_b_i <= b;
        dest_i <= d;
        @(posedge clk_i);
    endtask

    task automatic settle();
        op_valid_i <= 1'b0;
        op_i <= MAU_OP_NONE;
        // outputs launched two edges ago stand still at this edge
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_mult();
        issue(MAU_OP_MULT, 32'hfffffffd, 32'h7fffffff, 5'h00);
        settle();
        acc = smul(32'hfffffffd, 32'h7fffffff);
        check_pair("mult");
        issue(MAU_OP_MULTU, 32'hffffffff, 32'hffffffff, 5'h00);
        settle();
        acc = 64'(32'hffffffff) * 64'(32'hffffffff);
        check_pair("multu");
        issue(MAU_OP_MULT, 32'hffffffff, 32'h00000002, 5'h00);
        settle();
        acc = smul(32'hffffffff, 32'h00000002);
        check_pair("mult negative");
    endtask

    task automatic t_accum();
        issue(MAU_OP_MULT, 32'h12345678, 32'h9abcdef0, 5'h00);
        issue(MAU_OP_ACC_ADD, 32'h80000000, 32'h80000000, 5'h00);
        settle();
        acc = smul(32'h12345678, 32'h9abcdef0) + smul(32'h80000000, 32'h80000000);
        check_pair("acc add");
        issue(MAU_OP_ACC_SUB, 32'hffff0001, 32'h00c0ffee, 5'h00);
        settle();
        acc = acc - smul(32'hffff0001, 32'h00c0ffee);
        check_pair("acc sub");
    endtask

    task automatic t_prod();
        issue(MAU_OP_PROD, 32'hdeadbeef, 32'h00000003, 5'h07);
        issue(MAU_OP_PROD, 32'hfffffff0, 32'h00000011, 5'h1f);
        settle();
        check("prod r7", 32'(32'hdeadbeef * 32'h3), mau_regfile_model_inst.regs_q[7]);
        check("prod r31", 32'(smul(32'hfffffff0, 32'h11)), mau_regfile_model_inst.regs_q[31]);
        check_pair("pair after prod");
    endtask

    task automatic t_copy();
        // copies follow the multiply with no gap
        issue(MAU_OP_MULTU, 32'hcafef00d, 32'h13579bdf, 5'h00);
        issue(MAU_OP_CPTOP, 32'h0, 32'h0, 5'h03);
        issue(MAU_OP_CPBOT, 32'h0, 32'h0, 5'h04);
        settle();
        acc = 64'(32'hcafef00d) * 64'(32'h13579bdf);
        check("copy top", acc[63:32], mau_regfile_model_inst.regs_q[3]);
        check("copy bottom", acc[31:0], mau_regfile_model_inst.regs_q[4]);
    endtask

    task automatic t_div(input mau_op_t op, input logic [31:0] a, input logic [31:0] b);
        issue(op, a, b, 5'h00);
        // a multiply offered mid divide must be dropped
        issue(MAU_OP_MULT, 32'h5, 32'h5, 5'h00);
        op_valid_i <= 1'b0;
        check("busy during divide", 32'h1, {31'h0, busy_o});
        for (int i = 0; i < 60 && busy_o !== 1'b0; i++) begin
            @(posedge clk_i);
            #1;
        end
        // a divide that never ends counts as a mismatch here
        check("busy after divide", 32'h0, {31'h0, busy_o});
        if (op == MAU_OP_DIV) begin
            acc = {32'(signed'(a) % signed'(b)), 32'(signed'(a) / signed'(b))};
        end else begin
            acc = {a % b, a / b};
        end
        check_pair("divide");
        @(posedge clk_i);
    endtask

    initial begin
        repeat (20) @(posedge clk_i);
        reset_i <= 1'b0;
        check_pair("after reset");
        t_mult();
        t_accum();
        t_prod();
        t_copy();
        t_div(MAU_OP_DIVU, 32'hffffffff, 32'h00000010);
        t_div(MAU_OP_DIV, 32'hffffff9c, 32'h00000007);
        report_and_stop();
    end
endmodule
